/* core/emm_io_decode.sv */
/*
 Decodes the page-register I/O addresses for all four pages.
 Assumes the base select code has already been registered by the caller.
*/
`timescale 1ns/1ns
module emm_io_decode
    import emm_pkg::*;
(
    // Select code and address
    input  wire logic [3:0]  base_code,
    input  wire logic [15:0] io_addr,
    // Per-page hit
    output logic [3:0]       page_hit
);
    logic [15:0] base_addr;

    // Code n moves the pair by n*16; reserved codes still decode the same way
    assign base_addr = EMM_PAGE_IO_BASE | {8'h00, base_code, 4'h0};

    genvar gi;
    generate
        for (gi = 0; gi < EMM_NUM_PAGES; gi++)
        begin : g_page
            // Low address bit picks 2x8 or 2x9; both reach the same register
            assign page_hit[gi] = ((io_addr & EMM_PAGE_IO_MASK) ==
                                  (base_addr | (EMM_PAGE_IO_STEP * 16'(gi))));
        end
    endgenerate
endmodule

/* core/emm_regs.sv */
/*
 Register bank of the expanded-memory mapper: indexed port pair at 22H/23H,
 four page registers at configurable I/O pairs, address-20 gating and
 expanded-memory translation. Assumes one-cycle I/O read/write strobes
 synchronous to sys_clk, with 8-bit data.
*/
`timescale 1ns/1ns

module emm_regs
    import emm_pkg::*;
#(
    parameter bit LATER_REV = 1'b1
)
(
    // Clock and reset
    input  wire logic        sys_clk,
    input  wire logic        rst,
    // Processor I/O cycle
    input  wire logic [15:0] io_addr,
    input  wire logic        io_wr,
    input  wire logic        io_rd,
    input  wire logic [7:0]  io_wdata,
    output logic [7:0]       io_rdata,
    output logic             io_rdata_valid,
    // Processor memory address
    input  wire logic [23:0] cpu_addr,
    input  wire logic        addr20_gate_input,
    // Translated memory address
    output logic [22:0]      mem_addr,
    output logic             expanded_memory_hit,
    output logic             mem_addr20,
    // Controls to the DRAM sequencer
    output logic             ras_timeout_run,
    output logic             early_translate,
    output logic             ext_expanded_memory_en,
    output logic [2:0]       expanded_memory_size
);
    logic [7:0]  index_ff,      nxt_index;
    logic [7:0]  ext_ff,        nxt_ext;
    logic [7:0]  misc_ff,       nxt_misc;
    logic [7:0]  winbase_ff,    nxt_winbase;
    logic [7:0]  dramcfg_ff,    nxt_dramcfg;
    logic [31:0] page_ff,       nxt_page;
    logic [7:0]  rdata_ff,      nxt_rdata;
    logic        rvalid_ff,     nxt_rvalid;
    logic [3:0]  page_hit;
    logic        idx_sel,       data_sel;
    logic        xl_hit;
    logic [22:0] xl_addr;
    logic [7:0]  misc_wmask;
    // Revision default fixed at elaboration so reset loads a constant
    localparam logic [7:0] MISC_RST = LATER_REV ? EMM_MISC_RST_B : EMM_MISC_RST_A;

    assign misc_wmask = LATER_REV ? EMM_MISC_WMASK_B : EMM_MISC_WMASK_A;
    assign idx_sel    = (io_addr == EMM_INDEX_PORT);
    assign data_sel   = (io_addr == EMM_DATA_PORT);

    // Page-register I/O decode from the base select low nibble
    emm_io_decode u_decode
    (
        .base_code (winbase_ff[3:0]),
        .io_addr   (io_addr),
        .page_hit  (page_hit)
    );

    // Window match and address forming
    emm_translate u_xlate
    (
        .xlate_en  (dramcfg_ff[EMM_DRAMCFG_EN_BIT]),
        .win_code  (winbase_ff[7:4]),
        .ext_reg   (ext_ff),
        .page_regs (page_ff),
        .cpu_addr  (cpu_addr),
        .hit       (xl_hit),
        .mem_addr  (xl_addr)
    );

    // Register write and read-back next state
    always_comb
    begin
        nxt_index   = index_ff;
        nxt_ext     = ext_ff;
        nxt_misc    = misc_ff;
        nxt_winbase = winbase_ff;
        nxt_dramcfg = dramcfg_ff;
        nxt_page    = page_ff;
        nxt_rdata   = rdata_ff;
        nxt_rvalid  = 1'b0;
        if (io_wr)
        begin
            if (idx_sel)
            begin
                nxt_index = io_wdata;
            end
            else if (data_sel)
            begin
                unique case (index_ff)
                    EMM_IDX_EXT:     nxt_ext     = io_wdata;
                    EMM_IDX_MISC:    nxt_misc    = io_wdata & misc_wmask;
                    EMM_IDX_WINBASE: nxt_winbase = io_wdata;
                    EMM_IDX_DRAMCFG: nxt_dramcfg = io_wdata;
                    default:         nxt_index   = index_ff;           // Other indices belong elsewhere
                endcase
            end
            // Both addresses of a pair write the same page register
            for (int p = 0; p < EMM_NUM_PAGES; p++)
            begin
                if (page_hit[p])
                begin
                    nxt_page[8*p +: 8] = io_wdata;
                end
            end
        end
        if (io_rd)
        begin
            nxt_rvalid = 1'b1;
            nxt_rdata  = 8'h00;
            if (idx_sel)
            begin
                nxt_rdata = index_ff;
            end
            else if (data_sel)
            begin
                unique case (index_ff)
                    EMM_IDX_EXT:     nxt_rdata = ext_ff;
                    EMM_IDX_MISC:    nxt_rdata = misc_ff;
                    EMM_IDX_WINBASE: nxt_rdata = winbase_ff;
                    EMM_IDX_DRAMCFG: nxt_rdata = dramcfg_ff;
                    default:         nxt_rdata = 8'h00;
                endcase
            end
            for (int p = 0; p < EMM_NUM_PAGES; p++)
            begin
                if (page_hit[p])
                begin
                    nxt_rdata = page_ff[8*p +: 8];
                end
            end
        end
    end

    // Registers; reset values are constants only
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            index_ff   <= 8'h00;
            ext_ff     <= EMM_EXT_RST;
            misc_ff    <= MISC_RST;
            winbase_ff <= EMM_WINBASE_RST;
            dramcfg_ff <= EMM_DRAMCFG_RST;
            page_ff    <= {EMM_NUM_PAGES{EMM_PAGE_RST}};
            rdata_ff   <= 8'h00;
            rvalid_ff  <= 1'b0;
        end
        else
        begin
            index_ff   <= nxt_index;
            ext_ff     <= nxt_ext;
            misc_ff    <= nxt_misc;
            winbase_ff <= nxt_winbase;
            dramcfg_ff <= nxt_dramcfg;
            page_ff    <= nxt_page;
            rdata_ff   <= nxt_rdata;
            rvalid_ff  <= nxt_rvalid;
        end
    end

    assign io_rdata       = rdata_ff;
    assign io_rdata_valid = rvalid_ff;

    // Address 20: translated bit for a window hit, else CPU line, gated only when the misc address-20 bit is set.
    // Combinational on purpose: the address path cannot afford a cycle.
    always_comb
    begin
        expanded_memory_hit = xl_hit;
        mem_addr            = xl_hit ? xl_addr : cpu_addr[22:0];
        if (xl_hit)
        begin
            mem_addr20 = xl_addr[20];
        end
        else if (misc_ff[EMM_MISC_A20_BIT])
        begin
            mem_addr20 = cpu_addr[20] & addr20_gate_input;
        end
        else
        begin
            mem_addr20 = cpu_addr[20];
        end
    end

    // Static controls toward the DRAM sequencer
    assign ras_timeout_run        = ~misc_ff[EMM_MISC_RASTO_BIT];
    assign early_translate        = misc_ff[EMM_MISC_EARLY_BIT];
    assign ext_expanded_memory_en = misc_ff[EMM_MISC_EXTMEM_BIT];
    assign expanded_memory_size   = misc_ff[EMM_MISC_SIZE_LSB +: 3];
endmodule

/* core/emm_translate.sv */
/*
 Combinational address translator for the four expanded-memory windows.
 Assumes registered page, extension and base values from the register bank.
*/
`timescale 1ns/1ns
module emm_translate
    import emm_pkg::*;
(
    // Configuration
    input  wire logic        xlate_en,
    input  wire logic [3:0]  win_code,
    input  wire logic [7:0]  ext_reg,
    input  wire logic [31:0] page_regs,
    // Processor address
    input  wire logic [23:0] cpu_addr,
    // Result
    output logic             hit,
    output logic [22:0]      mem_addr
);
    logic [23:0] win_start;
    logic [1:0]  slot;
    logic [9:0]  rel;
    logic [7:0]  page;
    logic [1:0]  blk;

    always_comb
    begin
        win_start = EMM_WIN_ORIGIN + {6'h00, win_code, EMM_WIN_SHIFT'(0)};
        rel       = cpu_addr[23:14] - win_start[23:14];
        slot      = rel[1:0];
        page      = page_regs[8*slot +: 8];
        // Page 0 sits in the top field, page 3 in the bottom one
        blk       = ext_reg[6 - 2*slot +: 2];
        hit       = xlate_en && (rel < 10'(EMM_NUM_PAGES))
                    && page[EMM_PAGE_EN_BIT];
        mem_addr  = {blk, page[6:0], cpu_addr[13:0]};
    end
endmodule

/* shared/emm_pkg.sv */
/*
 Package for the expanded-memory mapper register bank: I/O port addresses,
 register indices, field positions, reset values and decode constants.
 Assumes a 16-bit I/O address and 8-bit data processor bus.
*/
package emm_pkg;
    // Indexed port pair
    localparam logic [15:0] EMM_INDEX_PORT   = 16'h0022;
    localparam logic [15:0] EMM_DATA_PORT    = 16'h0023;
    localparam logic [7:0]  EMM_IDX_DRAMCFG  = 8'h6b;
    localparam logic [7:0]  EMM_IDX_WINBASE  = 8'h6d;
    localparam logic [7:0]  EMM_IDX_EXT      = 8'h6e;
    localparam logic [7:0]  EMM_IDX_MISC     = 8'h6f;

    // Miscellaneous register fields, then the DRAM-config and page enable bits
    localparam int EMM_MISC_A20_BIT     = 1;
    localparam int EMM_MISC_RASTO_BIT   = 2;
    localparam int EMM_MISC_EARLY_BIT   = 3;
    localparam int EMM_MISC_EXTMEM_BIT  = 4;
    localparam int EMM_MISC_SIZE_LSB    = 5;
    localparam int EMM_DRAMCFG_EN_BIT   = 4;
    localparam int EMM_PAGE_EN_BIT      = 7;

    // Reset values; revision selects the address-20 control default
    localparam logic [7:0] EMM_EXT_RST      = 8'h00;
    localparam logic [7:0] EMM_MISC_RST_A   = 8'h00;
    localparam logic [7:0] EMM_MISC_RST_B   = 8'h02;
    localparam logic [7:0] EMM_PAGE_RST     = 8'h00;
    localparam logic [7:0] EMM_WINBASE_RST  = 8'h00;
    localparam logic [7:0] EMM_DRAMCFG_RST  = 8'hab;
    // Writable bits of the misc register per revision (bit 0 reserved)
    localparam logic [7:0] EMM_MISC_WMASK_A = 8'he4;
    localparam logic [7:0] EMM_MISC_WMASK_B = 8'hfe;

    // Page-register I/O decode: page n sits at (n<<14) | 2x8/2x9
    localparam logic [15:0] EMM_PAGE_IO_BASE = 16'h0208;
    localparam logic [15:0] EMM_PAGE_IO_STEP = 16'h4000;
    localparam logic [15:0] EMM_PAGE_IO_MASK = 16'hfffe;

    // Window placement: 16 KB windows starting at C0000H
    localparam logic [23:0] EMM_WIN_ORIGIN   = 24'h0c0000;
    localparam int          EMM_WIN_SHIFT    = 14;
    localparam int          EMM_NUM_PAGES    = 4;
endpackage

/* tb/emm_cpu_model.sv */
/* Processor model issuing one-cycle I/O strobes to the register bank.
   Assumes a read answer exactly one cycle after the strobe edge. */
`timescale 1ns/1ns
module emm_cpu_model (
    // Clock
    input wire logic        sys_clk,
    // I/O cycle
    output logic [15:0]     io_addr,
    output logic            io_wr,
    output logic            io_rd,
    output logic [7:0]      io_wdata,
    input wire logic [7:0]  io_rdata,
    input wire logic        io_rdata_valid
);
    initial
    begin
        io_addr  = 16'h0000;
        io_wr    = 1'b0;
        io_rd    = 1'b0;
        io_wdata = 8'h00;
    end

    // Released lines show the inverse so stale values never pass as fresh
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        #1 io_addr = a;
        io_wdata = d;
        io_wr    = 1'b1;
        @(posedge sys_clk);
        #1 io_wr = 1'b0;
        io_addr  = ~a;
        io_wdata = ~d;
    endtask

    // Answer taken in the cycle its valid pulse stands
    task automatic rd(input logic [15:0] a, output logic [7:0] d, output logic v);
        @(posedge sys_clk);
        #1 io_addr = a;
        io_rd = 1'b1;
        @(posedge sys_clk);
        #1 io_rd = 1'b0;
        io_addr = ~a;
        d       = io_rdata;
        v       = io_rdata_valid;
    endtask
endmodule

/* tb/emm_regs_sva.sv */
/* Checker for the mapper register bank, bound to its ports only.
   Assumes one clock and a synchronous active-high reset. */
`timescale 1ns/1ns
module emm_regs_sva (
    // Clock, reset, read side
    input wire logic        sys_clk,
    input wire logic        rst,
    input wire logic        io_rd,
    input wire logic [7:0]  io_rdata,
    input wire logic        io_rdata_valid,
    // Memory side
    input wire logic [23:0] cpu_addr,
    input wire logic        addr20_gate_input,
    input wire logic [22:0] mem_addr,
    input wire logic        expanded_memory_hit,
    input wire logic        mem_addr20,
    input wire logic        ras_timeout_run,
    input wire logic        ext_expanded_memory_en,
    input wire logic [2:0]  expanded_memory_size
);
    // One domain, so clock and reset are shared
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    AST_RD_VALID: assert property (io_rd |=> io_rdata_valid)
        else $error("read not answered next cycle");
    AST_NO_VALID: assert property (!io_rd |=> !io_rdata_valid)
        else $error("valid without a read");
    AST_RD_HOLD: assert property (!io_rd |=> $stable(io_rdata))
        else $error("read data moved without a read");
    AST_RST_VAL: assert property ($fell(rst) |-> ras_timeout_run && !expanded_memory_hit
        && !ext_expanded_memory_en && expanded_memory_size == 3'h0) else $error("bad reset outputs");
    AST_A20_ZERO: assert property (!expanded_memory_hit && !cpu_addr[20] |-> !mem_addr20)
        else $error("address 20 raised on its own");
    AST_A20_PASS: assert property (!expanded_memory_hit && addr20_gate_input |-> mem_addr20 == cpu_addr[20])
        else $error("address 20 not passed with gate open");
    AST_MISS_ADDR: assert property (!expanded_memory_hit |-> mem_addr[19:0] == cpu_addr[19:0])
        else $error("address changed outside windows");
    AST_HIT_LOW: assert property (expanded_memory_hit |-> mem_addr[13:0] == cpu_addr[13:0])
        else $error("offset bits altered");
    AST_HIT_WIN: assert property (expanded_memory_hit |-> cpu_addr[23:18] == 6'h03)
        else $error("hit outside window area");
    AST_HIT_A20: assert property (expanded_memory_hit |-> mem_addr20 == mem_addr[20])
        else $error("translated address 20 mismatch");
endmodule

bind emm_regs emm_regs_sva i_sva (.sys_clk, .rst, .io_rd, .io_rdata, .io_rdata_valid, .cpu_addr,
    .addr20_gate_input, .mem_addr, .expanded_memory_hit, .mem_addr20, .ras_timeout_run,
    .ext_expanded_memory_en, .expanded_memory_size);

/* tb/expanded_memory_mapper_regs_tb_top.sv */
/* Bench for the mapper register bank: a register model compared at every read
   and translated address. Assumes emm_cpu_model drives the I/O side. */
`timescale 1ns/1ns
module expanded_memory_mapper_regs_tb_top;
    import emm_pkg::*;
    logic        sys_clk, rst, io_wr, io_rd, io_rdata_valid, hit, a20, gate, ras_run, early, ext_en, v;
    logic [15:0] io_addr;
    logic [7:0]  io_wdata, io_rdata, d, rdata_o;
    logic [23:0] cpu_addr;
    logic [22:0] mem_addr;
    logic [2:0]  size;
    int          error_cnt, tests_run, m_ext, m_misc, m_cfg, m_base, i, k, pa, w;
    int          m_pg[4];
    int          io_c[7] = '{0, 1, 5, 6, 'ha, 'hb, 'he};

    emm_regs i_dut (.sys_clk(sys_clk), .rst(rst), .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd),
        .io_wdata(io_wdata), .io_rdata(io_rdata), .io_rdata_valid(io_rdata_valid), .cpu_addr(cpu_addr),
        .addr20_gate_input(gate), .mem_addr(mem_addr), .expanded_memory_hit(hit), .mem_addr20(a20),
        .ras_timeout_run(ras_run), .early_translate(early), .ext_expanded_memory_en(ext_en),
        .expanded_memory_size(size));
    // Original revision shares the bus; only its read-back is watched
    emm_regs #(.LATER_REV(1'b0)) i_dut_orig (.sys_clk(sys_clk), .rst(rst), .io_addr(io_addr), .io_wr(io_wr),
        .io_rd(io_rd), .io_wdata(io_wdata), .io_rdata(rdata_o), .io_rdata_valid(), .cpu_addr(cpu_addr),
        .addr20_gate_input(gate), .mem_addr(), .expanded_memory_hit(), .mem_addr20(), .ras_timeout_run(),
        .early_translate(), .ext_expanded_memory_en(), .expanded_memory_size());
    emm_cpu_model i_cpu (.sys_clk(sys_clk), .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd),
        .io_wdata(io_wdata), .io_rdata(io_rdata), .io_rdata_valid(io_rdata_valid));

    initial
    begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end

    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        tests_run++;
        if (s !== e)
        begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", n, e, s);
        end
    endtask

    task automatic wrap_up;
        $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // Indexed pair: index first, then the data port
    task automatic reg_wr(input logic [7:0] idx, input logic [7:0] dat);
        i_cpu.wr(EMM_INDEX_PORT, idx);
        i_cpu.wr(EMM_DATA_PORT, dat);
    endtask

    task automatic rd_chk(input logic [15:0] a, input logic [7:0] e);
        i_cpu.rd(a, d, v);
        chk("valid", v, 1'b1);
        chk("rdata", d, e);
    endtask

    task automatic reg_chk(input logic [7:0] idx, input logic [7:0] e);
        i_cpu.wr(EMM_INDEX_PORT, idx);
        rd_chk(EMM_DATA_PORT, e);
    endtask

    // Sequencer controls follow the misc register directly
    task automatic out_chk;
        chk("ras_run", ras_run, !m_misc[2]);
        chk("early", early, m_misc[3]);
        chk("ext_en", ext_en, m_misc[4]);
        chk("size", size, m_misc[7:5]);
    endtask

    // Expected translation worked out from the model registers
    task automatic xchk(input logic [23:0] a);
        logic [22:0] e_addr;
        logic        e_hit;
        @(posedge sys_clk);
        #1 cpu_addr = a;
        e_hit  = 1'b0;
        e_addr = a[22:0];
        for (int n = 0; n < 4; n++)
        begin
            w = 'hc0000 + ((m_base >> 4) + n) * 'h4000;
            if (m_cfg[4] && m_pg[n][7] && a[23:14] == w[23:14])
            begin
                e_hit  = 1'b1;
                e_addr = {m_ext[7 - 2 * n -: 2], m_pg[n][6:0], a[13:0]};
            end
        end
        #1 chk("hit", hit, e_hit);
        chk("mem_addr", mem_addr, e_addr);
        chk("a20", a20, e_hit ? e_addr[20] : a[20] & (gate | !m_misc[1]));
    endtask

    // Hang guard
    initial
    begin
        repeat (100000) @(posedge sys_clk);
        error_cnt++;
        wrap_up();
    end

    initial
    begin
        error_cnt = 0;
        tests_run = 0;
        rst       = 1'b1;
        cpu_addr  = 24'h000000;
        gate      = 1'b0;
        m_ext     = 0;
        m_misc    = 'h02;
        m_cfg     = 'hab;
        m_base    = 0;
        m_pg      = '{0, 0, 0, 0};
        void'($urandom(50517));
        repeat (20) @(posedge sys_clk);
        #1 rst = 1'b0;
        reg_chk(EMM_IDX_MISC, 8'h02);
        chk("misc_orig", rdata_o, 8'h00);
        reg_chk(EMM_IDX_DRAMCFG, 8'hab);
        reg_chk(EMM_IDX_EXT, 8'h00);
        out_chk();
        // Every size code; bit 0 sometimes written as one to see it dropped
        for (i = 0; i < 8; i++)
        begin
            d = {i[2:0], 5'($urandom)};
            reg_wr(EMM_IDX_MISC, d);
            m_misc = d & 8'hfe;
            reg_chk(EMM_IDX_MISC, 8'(m_misc));
            chk("misc_orig", rdata_o, 8'(m_misc & 'he4));
            out_chk();
        end
        // Gating select, gate input and processor address 20 in all combinations
        for (i = 0; i < 8; i++)
        begin
            reg_wr(EMM_IDX_MISC, {6'h00, i[2], 1'b0});
            m_misc = i[2] * 2;
            gate   = i[0];
            xchk(24'(i[1]) << 20);
        end
        reg_wr(EMM_IDX_DRAMCFG, 8'h10);
        m_cfg = 'h10;
        for (i = 0; i < 7; i++)
        begin
            m_base = ($urandom_range(8) << 4) | io_c[i];
            m_ext  = $urandom;
            reg_wr(EMM_IDX_WINBASE, 8'(m_base));
            reg_wr(EMM_IDX_EXT, 8'(m_ext));
            for (k = 0; k < 4; k++)
            begin
                pa       = (k << 14) | ('h208 + 16 * io_c[i]);
                m_pg[k]  = $urandom & 'hff;
                i_cpu.wr(16'(pa), 8'(m_pg[k]));
                rd_chk(16'(pa + 1), 8'(m_pg[k]));
                xchk(24'('hc0000 + ((m_base >> 4) + k) * 'h4000 + $urandom_range(16383)));
            end
            xchk(24'('hbffff + (m_base >> 4) * 'h4000));
            reg_chk(EMM_IDX_EXT, 8'(m_ext));
        end
        rd_chk(16'h0300, 8'h00);
        reg_wr(EMM_IDX_DRAMCFG, 8'h00);
        m_cfg = 0;
        xchk(24'('hc0000 + (m_base >> 4) * 'h4000));
        wrap_up();
    end
endmodule
